// ==== hdl/pgio_pin_bank.sv ====
`timescale 1ns/10ps
`default_nettype none
module pgio_pin_bank
  import pgio_pkg::*;
#(
  parameter int W = MID_W
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register side.
  pgio_bank_if.bank bi,
  // Pins.
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out_q,
  output logic [W-1:0] pin_oe_n_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] lat_q;
  logic [W-1:0] lat_d;
  logic [1:0] init_cnt_q;
  logic init_hit;
  logic init_done;

  // ------------------------------------------------------------
  // Pin capture and output latch
  // ------------------------------------------------------------
  assign init_hit = (init_cnt_q == INIT_LOAD);
  assign init_done = (init_cnt_q == INIT_DONE);
  // The latch takes the settled pin level once after reset.
  assign lat_d = bi.wr ? bi.wdata : (init_hit ? sync_q : lat_q);
  // Inputs show the pin, outputs show what software wrote.
  assign bi.rd = (bi.dir & lat_q) | (~bi.dir & sync_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_cnt_q <= '0;
      lat_q <= '0;
    end else begin
      if (!init_done) begin
        init_cnt_q <= init_cnt_q + 2'h1;
      end
      lat_q <= lat_d;
    end
  end

  // A disabled pin floats even if it is set as an output.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else begin
      pin_out_q <= lat_q;
      pin_oe_n_q <= ~(bi.en & bi.dir);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  float_off_a: assert property (
    1 |=> ((~pin_oe_n_q & ~$past(bi.en)) == '0))
    else $error("disabled pin was driven");
  drive_level_a: assert property (
    bi.wr ##1 !bi.wr |=> (pin_out_q == $past(bi.wdata, 2)))
    else $error("pin level differs from written data");
  input_read_a: assert property (
    init_done |-> ((bi.rd & ~bi.dir) == ($past(pin_in, 2) & ~bi.dir)))
    else $error("input read is not the pin level");
  reset_level_a: assert property (
    init_hit && !bi.wr |=> (lat_q == $past(sync_q)))
    else $error("data not loaded from pins after reset");
  keep_latch_a: assert property (
    init_done && !bi.wr |=> $stable(lat_q))
    else $error("data bit changed without a write");
  pin_drive_c: cover property (init_done ##1 (pin_oe_n_q != '1));

endmodule
`default_nettype wire

// ==== hdl/pgio_top.sv ====
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Mid data register bit 0 is line 16.
// - Input lines read back the sampled pin.
// - Output lines drive the written level.
// - Data bits start from the pin levels.
// - Upper enable bits, two reserved read/write bits.
// - Disabled pin floats, no function.
// - Enabled pin follows direction and data.
// - Upper direction bits, zero means input.
// - Upper data bits, two reserved read/write bits.
// - Mid data register at word index 0x4405.
module pgio_top
  import pgio_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Controls of lines 16 to 31, held elsewhere.
  input wire logic [MID_W-1:0] mid_enable,
  input wire logic [MID_W-1:0] mid_direction,
  // Pins of lines 16 to 31.
  input wire logic [MID_W-1:0] gpio_mid_in,
  output logic [MID_W-1:0] gpio_mid_out,
  output logic [MID_W-1:0] gpio_mid_oe_n,
  // Pins of lines 32 to 45.
  input wire logic [HI_W-1:0] gpio_hi_in,
  output logic [HI_W-1:0] gpio_hi_out,
  output logic [HI_W-1:0] gpio_hi_oe_n
);

  // ------------------------------------------------------------
  // Bus state
  // ------------------------------------------------------------
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic wr_pend_q;
  logic rd_pend_q;
  pgio_sel_t sel_q;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [REG_W-1:0] enable_hi_q;
  logic [REG_W-1:0] direction_hi_q;
  logic [RSV_W-1:0] level_hi_rsv_q;

  // ------------------------------------------------------------
  // Address phase decode
  // ------------------------------------------------------------
  logic take;
  logic hit_level_mid;
  logic hit_enable_hi;
  logic hit_dir_hi;
  logic hit_level_hi;
  pgio_sel_t addr_sel;

  assign take = hsel & htrans[1] & hready;
  assign hit_level_mid = (haddr == ADDR_LEVEL_MID);
  assign hit_enable_hi = (haddr == ADDR_ENABLE_HI);
  assign hit_dir_hi = (haddr == ADDR_DIR_HI);
  assign hit_level_hi = (haddr == ADDR_LEVEL_HI);

  // Unmapped addresses select nothing: reads give zero, writes vanish.
  assign addr_sel =
    hit_level_mid ? SEL_LEVEL_MID :
    hit_enable_hi ? SEL_ENABLE_HI :
    hit_dir_hi ? SEL_DIR_HI :
    hit_level_hi ? SEL_LEVEL_HI :
    SEL_NONE;

  // ------------------------------------------------------------
  // Data phase write strobes
  // ------------------------------------------------------------
  logic wr_go;
  logic wr_level_mid;
  logic wr_enable_hi;
  logic wr_dir_hi;
  logic wr_level_hi;

  assign wr_go = wr_pend_q & hready;
  assign wr_level_mid = wr_go & (sel_q == SEL_LEVEL_MID);
  assign wr_enable_hi = wr_go & (sel_q == SEL_ENABLE_HI);
  assign wr_dir_hi = wr_go & (sel_q == SEL_DIR_HI);
  assign wr_level_hi = wr_go & (sel_q == SEL_LEVEL_HI);

  // ------------------------------------------------------------
  // Pin banks
  // ------------------------------------------------------------
  pgio_bank_if #(.W(MID_W)) mid_if();
  pgio_bank_if #(.W(HI_W)) hi_if();

  assign mid_if.wr = wr_level_mid;
  assign mid_if.wdata = hwdata[MID_W-1:0];
  assign mid_if.en = mid_enable;
  assign mid_if.dir = mid_direction;

  assign hi_if.wr = wr_level_hi;
  assign hi_if.wdata = hwdata[HI_W-1:0];
  assign hi_if.en = enable_hi_q[HI_W-1:0];
  assign hi_if.dir = direction_hi_q[HI_W-1:0];

  pgio_pin_bank #(.W(MID_W)) u_mid_bank (
    .hclk(hclk),
    .hresetn(hresetn),
    .bi(mid_if.bank),
    .pin_in(gpio_mid_in),
    .pin_out_q(gpio_mid_out),
    .pin_oe_n_q(gpio_mid_oe_n)
  );

  pgio_pin_bank #(.W(HI_W)) u_hi_bank (
    .hclk(hclk),
    .hresetn(hresetn),
    .bi(hi_if.bank),
    .pin_in(gpio_hi_in),
    .pin_out_q(gpio_hi_out),
    .pin_oe_n_q(gpio_hi_oe_n)
  );

  // ------------------------------------------------------------
  // Read selection
  // ------------------------------------------------------------
  logic [REG_W-1:0] rd_level_mid;
  logic [REG_W-1:0] rd_level_hi;
  logic [REG_W-1:0] rd_reg;

  assign rd_level_mid = mid_if.rd;
  assign rd_level_hi = {level_hi_rsv_q, hi_if.rd};
  assign rd_reg =
    (sel_q == SEL_LEVEL_MID) ? rd_level_mid :
    (sel_q == SEL_ENABLE_HI) ? enable_hi_q :
    (sel_q == SEL_DIR_HI) ? direction_hi_q :
    (sel_q == SEL_LEVEL_HI) ? rd_level_hi :
    REG_RESET;

  // ------------------------------------------------------------
  // Bus sequencing
  // ------------------------------------------------------------
  // Reads wait one cycle so that a write taken just before them is
  // already in the registers when the read word is formed.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      sel_q <= SEL_NONE;
    end else begin
      if (take) begin
        wr_pend_q <= hwrite & (hsize == SIZE_WORD);
        rd_pend_q <= ~hwrite;
        sel_q <= addr_sel;
      end else if (hready) begin
        wr_pend_q <= 1'b0;
        rd_pend_q <= 1'b0;
      end else if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hrdata_q <= RDATA_RESET;
      hresp_q <= HRESP_OKAY;
    end else begin
      if (take && !hwrite) begin
        hreadyout_q <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout_q <= 1'b1;
        hrdata_q <= {UPPER_ZERO, rd_reg};
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // ------------------------------------------------------------
  // Control registers of lines 32 to 45
  // ------------------------------------------------------------
  // Reserved bits are storage only; they reach no pin.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_hi_q <= REG_RESET;
      direction_hi_q <= REG_RESET;
      level_hi_rsv_q <= RSV_RESET;
    end else begin
      if (wr_enable_hi) begin
        enable_hi_q <= hwdata[REG_W-1:0];
      end
      if (wr_dir_hi) begin
        direction_hi_q <= hwdata[REG_W-1:0];
      end
      if (wr_level_hi) begin
        level_hi_rsv_q <= hwdata[REG_W-1:HI_W];
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  read_wait_a: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");
  write_nowait_a: assert property (
    take && hwrite |=> hreadyout)
    else $error("write data phase was stretched");
  mid_map_a: assert property (
    rd_pend_q && sel_q == SEL_LEVEL_MID
      |=> hrdata == {UPPER_ZERO, $past(mid_if.rd)})
    else $error("mid data lanes misplaced");
  mid_addr_a: assert property (
    take && haddr == ADDR_LEVEL_MID |=> sel_q == SEL_LEVEL_MID)
    else $error("mid data address not decoded");
  enable_store_a: assert property (
    take && hwrite && hsize == SIZE_WORD && haddr == ADDR_ENABLE_HI
      ##1 hready |=> enable_hi_q == $past(hwdata[REG_W-1:0]))
    else $error("enable register not written");
  dir_store_a: assert property (
    wr_dir_hi |=> hi_if.dir == $past(hwdata[HI_W-1:0]))
    else $error("direction register not written");
  rsv_read_a: assert property (
    rd_pend_q && sel_q == SEL_LEVEL_HI
      |=> hrdata[REG_W-1:HI_W] == $past(level_hi_rsv_q))
    else $error("reserved data bits misread");
  unmapped_a: assert property (
    rd_pend_q && sel_q == SEL_NONE |=> hrdata == RDATA_RESET)
    else $error("unmapped read not zero");
  okay_resp_a: assert property (
    hresp == HRESP_OKAY)
    else $error("response was not OKAY");

  // ------------------------------------------------------------
  // Register file checks
  // ------------------------------------------------------------
  en_read_a: assert property (
    rd_pend_q && sel_q == SEL_ENABLE_HI
      |=> hrdata == {UPPER_ZERO, $past(enable_hi_q)})
    else $error("enable register misread");
  en_keep_a: assert property (
    !wr_enable_hi |=> $stable(enable_hi_q))
    else $error("enable register changed without a write");
  dir_read_a: assert property (
    rd_pend_q && sel_q == SEL_DIR_HI
      |=> hrdata == {UPPER_ZERO, $past(direction_hi_q)})
    else $error("direction register misread");
  dir_keep_a: assert property (
    !wr_dir_hi |=> $stable(direction_hi_q))
    else $error("direction register changed without a write");
  dir_commit_a: assert property (
    take && hwrite && hsize == SIZE_WORD && haddr == ADDR_DIR_HI
      ##1 hready |=> direction_hi_q == $past(hwdata[REG_W-1:0]))
    else $error("direction write did not commit");
  hi_read_a: assert property (
    rd_pend_q && sel_q == SEL_LEVEL_HI
      |=> hrdata[HI_W-1:0] == $past(hi_if.rd))
    else $error("upper data lanes misplaced");
  rsv_store_a: assert property (
    wr_level_hi |=> level_hi_rsv_q == $past(hwdata[REG_W-1:HI_W]))
    else $error("reserved data bits not written");
  rsv_keep_a: assert property (
    !wr_level_hi |=> $stable(level_hi_rsv_q))
    else $error("reserved data bits changed without a write");

  // ------------------------------------------------------------
  // Bus checks
  // ------------------------------------------------------------
  // A refused write must leave every register untouched.
  narrow_drop_a: assert property (
    take && hwrite && hsize != SIZE_WORD |=> !wr_go)
    else $error("narrow write was not ignored");
  unmapped_wr_a: assert property (
    take && hwrite && addr_sel == SEL_NONE
      |=> !(wr_level_mid || wr_enable_hi || wr_dir_hi || wr_level_hi))
    else $error("unmapped write reached a register");
  sel_hold_a: assert property (
    !take |=> $stable(sel_q))
    else $error("register select moved without a transfer");
  rd_pair_a: assert property (
    take && !hwrite |=> rd_pend_q)
    else $error("read not registered as pending");
  rd_finish_a: assert property (
    rd_pend_q |=> hreadyout)
    else $error("read wait state not released");
  rd_stand_a: assert property (
    !rd_pend_q |=> $stable(hrdata))
    else $error("read data changed outside a read");
  ready_hold_a: assert property (
    !rd_pend_q && !(take && !hwrite) |=> $stable(hreadyout))
    else $error("ready changed outside a read");

  // ------------------------------------------------------------
  // Pin checks
  // ------------------------------------------------------------
  // The pin flops lag the registers by one edge, hence the $past.
  hi_float_a: assert property (
    1 |=> (~gpio_hi_oe_n & ~$past(enable_hi_q[HI_W-1:0])) == '0)
    else $error("disabled upper pin was driven");
  mid_float_a: assert property (
    1 |=> (~gpio_mid_oe_n & ~$past(mid_enable)) == '0)
    else $error("disabled mid pin was driven");
  hi_enable_a: assert property (
    1 |=> gpio_hi_oe_n ==
      ~($past(enable_hi_q[HI_W-1:0]) & $past(direction_hi_q[HI_W-1:0])))
    else $error("upper pin drive does not follow enable and direction");
  mid_enable_a: assert property (
    1 |=> gpio_mid_oe_n == ~($past(mid_enable) & $past(mid_direction)))
    else $error("mid pin drive does not follow enable and direction");
  hi_out_a: assert property (
    hi_if.wr ##1 !hi_if.wr |=> gpio_hi_out == $past(hwdata[HI_W-1:0], 2))
    else $error("upper pin level differs from written data");
  mid_out_a: assert property (
    mid_if.wr ##1 !mid_if.wr |=> gpio_mid_out == $past(hwdata[MID_W-1:0], 2))
    else $error("line 16 is not bit 0 of the mid data register");

  enable_wr_c: cover property (wr_enable_hi);
  level_rd_c: cover property (rd_pend_q && sel_q == SEL_LEVEL_HI);
  back2back_c: cover property (wr_go && take && !hwrite);
  hi_drive_c: cover property (gpio_hi_oe_n != '1 && gpio_hi_out != '0);

endmodule
`default_nettype wire

// ==== include/pgio_bank_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface pgio_bank_if #(
  parameter int W = pgio_pkg::MID_W
);
  logic wr;
  logic [W-1:0] wdata;
  logic [W-1:0] en;
  logic [W-1:0] dir;
  logic [W-1:0] rd;
  modport bank(input wr, input wdata, input en, input dir, output rd);
  modport ctl(output wr, output wdata, output en, output dir, input rd);
endinterface
`default_nettype wire

// ==== include/pgio_pkg.sv ====
package pgio_pkg;

  // ------------------------------------------------------------
  // Register map (word index; byte address is four times it)
  // ------------------------------------------------------------
  localparam logic [29:0] IDX_LEVEL_MID = 30'h0000_4405;
  localparam logic [29:0] IDX_ENABLE_HI = 30'h0000_4406;
  localparam logic [29:0] IDX_DIR_HI = 30'h0000_4407;
  localparam logic [29:0] IDX_LEVEL_HI = 30'h0000_4408;
  localparam logic [31:0] ADDR_LEVEL_MID = {IDX_LEVEL_MID, 2'h0};
  localparam logic [31:0] ADDR_ENABLE_HI = {IDX_ENABLE_HI, 2'h0};
  localparam logic [31:0] ADDR_DIR_HI = {IDX_DIR_HI, 2'h0};
  localparam logic [31:0] ADDR_LEVEL_HI = {IDX_LEVEL_HI, 2'h0};

  // ------------------------------------------------------------
  // Widths, fields and reset values
  // ------------------------------------------------------------
  localparam int MID_W = 16;
  localparam int HI_W = 14;
  localparam int REG_W = 16;
  localparam int RSV_W = 2;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [RSV_W-1:0] RSV_RESET = 2'h0;
  localparam logic [15:0] UPPER_ZERO = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Bus encodings and pin-level capture timing
  // ------------------------------------------------------------
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic [1:0] INIT_LOAD = 2'h2;
  localparam logic [1:0] INIT_DONE = 2'h3;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_LEVEL_MID = 3'h1,
    SEL_ENABLE_HI = 3'h2,
    SEL_DIR_HI = 3'h3,
    SEL_LEVEL_HI = 3'h4
  } pgio_sel_t;

endpackage

// ==== tb/pgio_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pgio_pin_model #(
  parameter int W = 16
) (
  // Board side.
  input wire logic [W-1:0] ext,
  // Block pins.
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe_n,
  // Resolved wire.
  output logic [W-1:0] level
);
  // A released pin shows what the board drives; the board never lets a line float.
  assign level = (oe_n & ext) | (~oe_n & out);
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench
  import pgio_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, w;
  logic [31:0] hrd_n = 32'h0;
  logic hreadyout, hresp;
  logic rdy_n = 1'b1;
  logic [15:0] mid_en = 16'h0;
  logic [15:0] mid_dir = 16'h0;
  logic [15:0] ext_mid, mid_out, mid_oe_n, mid_lvl;
  logic [13:0] ext_hi, hi_out, hi_oe_n, hi_lvl;
  bit [15:0] m_en, m_dir, m_dat, m_mid;
  int err_total = 0;
  int num_checks = 0;
  int seed = 28;

  initial forever #12.5 hclk = ~hclk;
  // Outputs are registers, so the value at the falling edge is the one the next rising edge sees.
  always @(negedge hclk) begin
    rdy_n <= hreadyout;
    hrd_n <= hrdata;
  end

  pgio_top i_pgio_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mid_enable(mid_en),
    .mid_direction(mid_dir), .gpio_mid_in(mid_lvl), .gpio_mid_out(mid_out),
    .gpio_mid_oe_n(mid_oe_n), .gpio_hi_in(hi_lvl), .gpio_hi_out(hi_out), .gpio_hi_oe_n(hi_oe_n));
  pgio_pin_model #(.W(16)) i_pgio_pin_model_mid (.ext(ext_mid), .out(mid_out),
    .oe_n(mid_oe_n), .level(mid_lvl));
  pgio_pin_model #(.W(14)) i_pgio_pin_model_hi (.ext(ext_hi), .out(hi_out),
    .oe_n(hi_oe_n), .level(hi_lvl));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task bus(input logic wr, input logic [2:0] sz, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    @(posedge hclk);
    while (rdy_n !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (rdy_n !== 1'b1) @(posedge hclk);
    rd = hrd_n;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, SIZE_WORD, a, d);
  endtask

  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, SIZE_WORD, a, 32'h0);
    check(rd, exp);
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  function automatic logic [31:0] exp_hi();
    return {16'h0, m_dat[15:14], (m_dat[13:0] & m_dir[13:0]) | (ext_hi & ~m_dir[13:0])};
  endfunction

  function automatic logic [31:0] exp_mid();
    return {16'h0, (m_mid & mid_dir) | (ext_mid & ~mid_dir)};
  endfunction

  task pins_chk();
    logic [13:0] mh;
    logic [15:0] mm;
    mh = m_en[13:0] & m_dir[13:0];
    mm = mid_en & mid_dir;
    check({18'h0, hi_oe_n}, {18'h0, ~mh});
    check({18'h0, hi_out & mh}, {18'h0, m_dat[13:0] & mh});
    check({16'h0, mid_oe_n}, {16'h0, ~mm});
    check({16'h0, mid_out & mm}, {16'h0, m_mid & mm});
  endtask

  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    w = $random(seed);
    ext_mid <= w[15:0];
    ext_hi <= w[29:16];
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    m_mid = ext_mid;
    m_dat = {2'h0, ext_hi};
    m_en = 16'h0;
    m_dir = 16'h0;
    rdchk(ADDR_ENABLE_HI, 32'h0);
    rdchk(ADDR_DIR_HI, 32'h0);
    rdchk(ADDR_LEVEL_HI, exp_hi());
    rdchk(ADDR_LEVEL_MID, exp_mid());
    rdchk(32'h0001_1024, 32'h0);
    pins_chk();
    $display("test reset_values done");
    // Pins move away so that only the level caught at reset can match.
    ext_hi <= ~ext_hi;
    ext_mid <= ~ext_mid;
    mid_dir <= 16'hffff;
    wr(ADDR_DIR_HI, 32'hffff_ffff);
    m_dir = 16'hffff;
    repeat (4) @(posedge hclk);
    rdchk(ADDR_LEVEL_HI, exp_hi());
    rdchk(ADDR_LEVEL_MID, exp_mid());
    pins_chk();
    $display("test reset_level done");
    for (int i = 0; i < 24; i++) begin
      w = $random(seed);
      wr(ADDR_ENABLE_HI, w);
      m_en = w[15:0];
      w = $random(seed);
      wr(ADDR_DIR_HI, w);
      m_dir = w[15:0];
      w = $random(seed);
      wr(ADDR_LEVEL_HI, w);
      m_dat = w[15:0];
      w = $random(seed);
      wr(ADDR_LEVEL_MID, w);
      m_mid = w[15:0];
      w = $random(seed);
      mid_en <= w[15:0];
      mid_dir <= w[31:16];
      w = $random(seed);
      ext_mid <= w[15:0];
      ext_hi <= w[29:16];
      repeat (4) @(posedge hclk);
      rdchk(ADDR_ENABLE_HI, {16'h0, m_en});
      rdchk(ADDR_DIR_HI, {16'h0, m_dir});
      rdchk(ADDR_LEVEL_HI, exp_hi());
      rdchk(ADDR_LEVEL_MID, exp_mid());
      pins_chk();
    end
    $display("test random_traffic done");
    bus(1'b1, 3'h1, ADDR_ENABLE_HI, ~{16'h0, m_en});
    wr(32'h0001_1024, 32'hffff_ffff);
    rdchk(ADDR_ENABLE_HI, {16'h0, m_en});
    rdchk(ADDR_LEVEL_HI, exp_hi());
    $display("test refused_writes done");
    end_of_test();
  end

  initial begin
    #(25 * 20000);
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
